// ### sbp_defines.vh
// Purpose: Shared constants for the sector/block protection logic.
// Assumes: 250 MHz clock, protection bits held in flip-flops.
// Notes:   Timing figures are in microseconds; cycle counts derive here.
`ifndef SBP_DEFINES_VH
`define SBP_DEFINES_VH

// Number of 64 KB blocks that carry one bit pair each.
`define SBP_NUM_BLOCKS      510
// Number of small 4 KB sectors carrying individual bit pairs.
`define SBP_NUM_SMALL       32
// Total bit pairs: blocks plus small sectors.
`define SBP_NUM_BITS        542
// Index width covering 0 to 541.
`define SBP_IDX_W           10
// Byte address width of the array (32 MB).
`define SBP_ADDR_W          25
// Bit position of the 64 KB block number in the address.
`define SBP_BLOCK_LSB       16
// Bit position of the 4 KB sector number in the address.
`define SBP_SECTOR_LSB      12
// Clock period in picoseconds (250 MHz).
`define SBP_CLK_PS          4000
// Typical page program time in microseconds.
`define SBP_PROG_US         200
// Typical sector erase time in microseconds.
`define SBP_ERASE_US        45
// Program cycles: rounded down, no floor at one (50000 here).
`define SBP_PROG_CYC        ((`SBP_PROG_US * 1000000) / `SBP_CLK_PS)
// Erase cycles: rounded down, no floor at one (11250 here).
`define SBP_ERASE_CYC       ((`SBP_ERASE_US * 1000000) / `SBP_CLK_PS)
// Power-up value of every non-volatile persistent bit (erased, unprotected).
`define SBP_PPB_ERASED      1'h1
// Reset value of every dynamic bit (unprotected).
`define SBP_DYB_RESET       1'h1

`endif

// ### sbp_map.v
// Purpose: Maps a byte address to its protection bit index.
// Assumes: Address is a byte address inside the 32 MB array.
// Notes:   Pure combinational; two small-sector orientations supported.
`timescale 1ns/1ps
`include "sbp_defines.vh"

module sbp_map
(
    input  wire [`SBP_ADDR_W-1:0] addr,      // Byte address.
    input  wire                   top_small, // High when small sectors on top.
    output reg  [`SBP_IDX_W-1:0]  index      // Protection bit index.
);

    // Block and sector numbers sliced from the address.
    wire [8:0]  block_num;
    wire [4:0]  sect_low;

    assign block_num = addr[`SBP_ADDR_W-1:`SBP_BLOCK_LSB];
    assign sect_low  = addr[`SBP_BLOCK_LSB:`SBP_SECTOR_LSB];

    // Top orientation gives blocks 0..509 their own index, then sectors of
    // blocks 510/511 take 510..541; bottom mirrors this with sectors first.
    always @*
    begin
        if (top_small)
        begin
            if (block_num >= 9'h1FE)
                index = 10'h1FE + {5'h00, sect_low};
            else
                index = {1'b0, block_num};
        end
        else
        begin
            if (block_num <= 9'h001)
                index = {5'h00, sect_low};
            else
                index = {1'b0, block_num} + 10'h01E;
        end
    end

endmodule

// ### sbp_protect.v
// Purpose: Per-sector/block persistent and dynamic protection with lock.
// Assumes: Commands arrive as one-cycle strobes from decoded SPI framing.
// Notes:   Persistent bits are flip-flops standing in for flash cells.
//          Program and erase times are counted in clock cycles; the
//          counts are parameters so that a test can shorten them.
//          Command framing, password compare and status encoding live
//          outside this block; only their decoded strobes arrive here.
`timescale 1ns/1ps
`include "sbp_defines.vh"

module sbp_protect
#(
    parameter integer PROG_CYC  = `SBP_PROG_CYC,  // Program busy time.
    parameter integer ERASE_CYC = `SBP_ERASE_CYC, // Erase busy time.
    parameter integer NUM_BITS  = `SBP_NUM_BITS   // Bit pairs in the map.
)
(
    input  wire                   clk,                   // 250 MHz clock.
    input  wire                   rst_n,                 // Hardware reset.
    input  wire                   ce,                    // Clock enable.
    input  wire                   soft_reset,            // Software reset.
    input  wire                   password_mode,         // High: password.
    input  wire                   small_sector_top_select, // Low: top.
    input  wire [`SBP_ADDR_W-1:0] addr,                  // Command address.
    input  wire                   prog_persistent_cmd,   // Program one bit.
    input  wire                   erase_persistent_cmd,  // Erase all bits.
    input  wire                   read_persistent_bit_cmd, // Read one bit.
    input  wire                   write_dynamic_bit_cmd, // Write one bit.
    input  wire                   dynamic_value,         // Value to write.
    input  wire                   clear_lock_cmd,        // Clear the lock.
    input  wire                   unlock_ok,             // Password matched.
    input  wire                   array_write_req,       // Array prog/erase.
    input  wire                   array_read_req,        // Array read.
    input  wire                   err_clear,             // Clear error flag.
    output reg                    persistent_bits_lock,  // Lock bit.
    output reg                    busy,                  // Operation running.
    output reg                    read_bit_valid,        // Read answer pulse.
    output reg                    read_bit_value,        // Read answer data.
    output reg                    array_write_grant,     // Array op allowed.
    output reg                    array_write_reject,    // Array op refused.
    output reg                    array_read_grant,      // Array read allowed.
    output reg                    protect_error          // Sticky error.
);

    // Operation states. Only one persistent-plane operation runs at a
    // time. While one runs, every command but the volatile ones (dynamic
    // write, lock clear, unlock, error clear) is dropped rather than queued, which keeps
    // the sequencer free of any command buffer.
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_PROG  = 2'h1;
    localparam [1:0] ST_ERASE = 2'h2;

    // Storage for the two bit planes, indexed by region.
    reg  [NUM_BITS-1:0]  persistent_prot_bit;  // Non-volatile plane.
    reg  [NUM_BITS-1:0]  dynamic_prot_bit;     // Volatile plane.
    reg  [1:0]           state;                // Current operation.
    reg  [31:0]          timer;                // Busy countdown.
    reg  [`SBP_IDX_W-1:0] op_index;            // Bit being programmed.
    reg                  hw_reset_seen;        // Lock reload pending.
    reg                  next_lock;            // Lock after this cycle.
    wire [`SBP_IDX_W-1:0] index;               // Mapped address index.
    wire                 region_protected;     // Addressed region state.

    // Address-to-index translation, shared by every addressed command.
    sbp_map u_map
    (
        .addr      (addr),
        .top_small (~small_sector_top_select),
        .index     (index)
    );

    // Either plane at zero protects the region. A programmed persistent
    // bit therefore overrides the dynamic bit, which only matters while
    // the persistent bit of that region is still erased.
    assign region_protected = ~persistent_prot_bit[index]
                            | ~dynamic_prot_bit[index];

    // Lock next value. Software reset is deliberately ignored here so that
    // a boot-time lock survives it. A hardware reset reloads the lock one
    // cycle later from the mode strap, since the strap is not a constant.
    always @*
    begin
        next_lock = persistent_bits_lock;
        if (hw_reset_seen)
            next_lock = ~password_mode;
        else if (clear_lock_cmd)
            next_lock = 1'b0;
        else if (password_mode && unlock_ok)
            next_lock = 1'b1;
    end

    // Lock register and reset capture. The capture flag is the only state
    // that remembers that a hardware reset has just ended; it lives one
    // cycle, so the strap is read exactly once per reset.
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            hw_reset_seen        <= 1'b1;
            persistent_bits_lock <= 1'b0;
        end
        else if (ce)
        begin
            hw_reset_seen        <= 1'b0;
            persistent_bits_lock <= next_lock;
        end
    end

    // Dynamic plane. The per-bit write decode is generated, but the plane
    // itself is one register written from a single process, so no bit of
    // it has more than one driver. Writes ignore the lock on purpose: the
    // dynamic bits are meant to be flipped freely at run time.
    wire [NUM_BITS-1:0] next_dyn;  // Plane value after this cycle's write.
    genvar g;
    generate
        for (g = 0; g < NUM_BITS; g = g + 1)
        begin : g_dyn
            // Region number of this bit, compared at full integer width.
            localparam integer REGION = g;
            // Only the addressed bit takes the written value.
            assign next_dyn[g] = (write_dynamic_bit_cmd &&
                                  {{(32-`SBP_IDX_W){1'b0}}, index} == REGION)
                               ? dynamic_value
                               : dynamic_prot_bit[g];
        end
    endgenerate

    // Dynamic plane register: one after hardware and software reset.
    always @(posedge clk)
    begin
        if (!rst_n)
            dynamic_prot_bit <= {NUM_BITS{`SBP_DYB_RESET}};
        else if (ce && soft_reset)
            // A software reset drops the dynamic protection of every region.
            dynamic_prot_bit <= {NUM_BITS{`SBP_DYB_RESET}};
        else if (ce)
            dynamic_prot_bit <= next_dyn;
    end

    // Persistent plane. Hardware reset does not clear it, as it stands in
    // for non-volatile cells. The erased factory state is loaded once, at
    // the first reset after power-up. The power flag wakes up with no
    // defined value, so only an exact one counts as powered; any other
    // value loads the erased state rather than leaving the plane unknown.
    reg powered;  // One once the first reset has been seen.
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            powered <= 1'b1;
            case (powered)
                1'b1:
                    // Later resets keep the programmed pattern.
                    persistent_prot_bit <= persistent_prot_bit;
                default:  // Power-up: every bit erased.
                    persistent_prot_bit <= {NUM_BITS{`SBP_PPB_ERASED}};
            endcase
        end
        else if (ce)
        begin
            if (state == ST_PROG && timer == 32'h00000001)
                persistent_prot_bit[op_index] <= 1'b0;
            else if (state == ST_ERASE && timer == 32'h00000001)
                persistent_prot_bit <= {NUM_BITS{1'b1}};
        end
    end

    // Operation sequencer with busy reporting and answers. Answers are
    // one-cycle pulses registered on the edge after the command is taken.
    // The bit change of a program or erase lands on the same edge at which
    // busy falls, so a status poll never sees idle before the new value.
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            state              <= ST_IDLE;
            timer              <= 32'h00000000;
            op_index           <= 10'h000;
            busy               <= 1'b0;
            read_bit_valid     <= 1'b0;
            read_bit_value     <= 1'b0;
            array_write_grant  <= 1'b0;
            array_write_reject <= 1'b0;
            array_read_grant   <= 1'b0;
            protect_error      <= 1'b0;
        end
        else if (ce)
        begin
            read_bit_valid     <= 1'b0;
            array_write_grant  <= 1'b0;
            array_write_reject <= 1'b0;
            array_read_grant   <= 1'b0;
            // Error set wins over a clear in the same cycle.
            if (err_clear)
                protect_error <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    if (prog_persistent_cmd || erase_persistent_cmd)
                    begin
                        if (!persistent_bits_lock)
                            protect_error <= 1'b1;
                        else if (prog_persistent_cmd)
                        begin
                            state    <= ST_PROG;
                            timer    <= PROG_CYC;
                            op_index <= index;
                            busy     <= 1'b1;
                        end
                        else
                        begin
                            state <= ST_ERASE;
                            timer <= ERASE_CYC;
                            busy  <= 1'b1;
                        end
                    end
                    else if (read_persistent_bit_cmd)
                    begin
                        read_bit_valid <= 1'b1;
                        read_bit_value <= persistent_prot_bit[index];
                    end
                    else if (array_write_req)
                    begin
                        if (region_protected)
                        begin
                            array_write_reject <= 1'b1;
                            protect_error      <= 1'b1;
                        end
                        else
                            array_write_grant <= 1'b1;
                    end
                    else if (array_read_req)
                        array_read_grant <= 1'b1;
                end
                ST_PROG, ST_ERASE:
                begin
                    // Array reads are refused by simply never granting.
                    if (timer == 32'h00000001)
                    begin
                        state <= ST_IDLE;
                        busy  <= 1'b0;
                    end
                    timer <= timer - 32'h00000001;
                end
                default:
                begin
                    state <= ST_IDLE;
                    busy  <= 1'b0;
                end
            endcase
        end
    end

endmodule

// ### sbp_protect_sva.sv
// Purpose: Port-level checks on the protection block.
// Assumes: Program and erase counts are shortened to 4 and 8 cycles.
// Notes:   Bound to every instance of the protection block.
`timescale 1ns/1ps
module sbp_protect_sva
(
    input logic clk,
    input logic rst_n,
    input logic ce,
    input logic password_mode,
    input logic prog_persistent_cmd,
    input logic erase_persistent_cmd,
    input logic read_persistent_bit_cmd,
    input logic unlock_ok,
    input logic persistent_bits_lock,
    input logic busy,
    input logic read_bit_valid,
    input logic array_write_reject,
    input logic array_read_grant,
    input logic protect_error
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // An idle read is answered on the very next edge.
    property p_read_ans;
        ce && read_persistent_bit_cmd && !busy && !prog_persistent_cmd &&
            !erase_persistent_cmd |=> read_bit_valid;
    endproperty
    a_read_ans: assert property (p_read_ans)
        else $error("read answer missing");
    // The mode strap decides the lock right after reset.
    property p_reset_lock;
        $rose(rst_n) |=> persistent_bits_lock == !password_mode;
    endproperty
    a_reset_lock: assert property (p_reset_lock)
        else $error("lock wrong after reset");
    // Persistent mode: a cleared lock stays cleared until reset.
    property p_no_raise;
        !password_mode && !persistent_bits_lock && $past(rst_n)
            |=> !persistent_bits_lock;
    endproperty
    a_no_raise: assert property (p_no_raise)
        else $error("lock raised in persistent mode");
    // Password mode: only a matched password raises the lock.
    property p_pw_raise;
        password_mode && !persistent_bits_lock && !unlock_ok && $past(rst_n)
            |=> !persistent_bits_lock;
    endproperty
    a_pw_raise: assert property (p_pw_raise)
        else $error("lock raised without unlock");
    // A program under a cleared lock fails with no busy period.
    property p_lock_fail;
        ce && prog_persistent_cmd && !busy && !persistent_bits_lock
            |=> protect_error && !busy;
    endproperty
    a_lock_fail: assert property (p_lock_fail)
        else $error("locked program not refused");
    // An allowed program shows busy on the next edge.
    property p_busy_start;
        ce && prog_persistent_cmd && !busy && persistent_bits_lock |=> busy;
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("busy did not rise");
    // Busy spans the internal program or erase time, then ends.
    property p_busy_len;
        $rose(busy) |-> busy [*3] ##[1:6] !busy;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy length wrong");
    // No array read is granted while an operation runs.
    property p_no_rd;
        busy |-> !array_read_grant;
    endproperty
    a_no_rd: assert property (p_no_rd)
        else $error("array read during busy");
    // A refused array write raises the error flag.
    property p_reject_err;
        array_write_reject |-> ##[0:1] protect_error;
    endproperty
    a_reject_err: assert property (p_reject_err)
        else $error("reject without error flag");
endmodule

bind sbp_protect sbp_protect_sva u_sva
(
    .clk(clk), .rst_n(rst_n), .ce(ce), .password_mode(password_mode),
    .prog_persistent_cmd(prog_persistent_cmd),
    .erase_persistent_cmd(erase_persistent_cmd),
    .read_persistent_bit_cmd(read_persistent_bit_cmd),
    .unlock_ok(unlock_ok), .persistent_bits_lock(persistent_bits_lock),
    .busy(busy), .read_bit_valid(read_bit_valid),
    .array_write_reject(array_write_reject),
    .array_read_grant(array_read_grant), .protect_error(protect_error)
);

// ### sbp_host.sv
// Purpose: Host model that issues decoded protection commands.
// Assumes: One strobe per command, held for exactly one clock.
// Notes:   Address is inverted once released so stale values never match.
`timescale 1ns/1ps
`include "sbp_defines.vh"
module sbp_host
(
    input  logic                   clk,
    output logic [`SBP_ADDR_W-1:0] addr,
    output logic                   dynamic_value,
    output logic [8:0]             cmd
);
    initial
    begin
        addr = 25'h0000000;
        dynamic_value = 1'h0;
        cmd = 9'h000;
    end
    // Raise one strobe after an edge and drop it after the next one.
    task automatic issue(input int op, input logic [24:0] a, input logic v);
        @(posedge clk);
        #1;
        addr = {a[24:12], 12'h000};
        dynamic_value = v;
        cmd[op] = 1'h1;
        @(posedge clk);
        #1;
        cmd = 9'h000;
        addr = ~addr;
        dynamic_value = ~v;
    endtask
endmodule

// ### test_sector_block_protection_bits.sv
// Purpose: Directed scenarios for the protection block.
// Assumes: Both sector orientations; clock enable mostly high.
// Notes:   Answers are sampled just after the edge that registers them.
`timescale 1ns/1ps
`include "sbp_defines.vh"
module test_sector_block_protection_bits;
    logic        clk, rst_n, soft_reset, password_mode, dynamic_value;
    logic        ce, top_sel;
    logic [24:0] addr;
    logic [8:0]  cmd;
    logic        lock, busy, rd_v, rd_d, wr_g, wr_r, rd_g, perr;
    int          errors, checked;
    sbp_host host (.clk(clk), .addr(addr), .dynamic_value(dynamic_value),
        .cmd(cmd));
    sbp_protect #(.PROG_CYC(4), .ERASE_CYC(8)) dut (.clk(clk),
        .rst_n(rst_n), .ce(ce), .soft_reset(soft_reset),
        .password_mode(password_mode), .small_sector_top_select(top_sel),
        .addr(addr), .prog_persistent_cmd(cmd[0]),
        .erase_persistent_cmd(cmd[1]), .read_persistent_bit_cmd(cmd[2]),
        .write_dynamic_bit_cmd(cmd[3]), .dynamic_value(dynamic_value),
        .clear_lock_cmd(cmd[4]), .unlock_ok(cmd[5]),
        .array_write_req(cmd[6]), .array_read_req(cmd[7]),
        .err_clear(cmd[8]), .persistent_bits_lock(lock), .busy(busy),
        .read_bit_valid(rd_v), .read_bit_value(rd_d),
        .array_write_grant(wr_g), .array_write_reject(wr_r),
        .array_read_grant(rd_g), .protect_error(perr));
    task automatic end_of_test;
        if (errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [1:0] got, input logic [1:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Bounded wait for the end of a program or erase.
    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'h0 && n < 20)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({1'h0, busy}, 2'h0);
        if (n == 20)
            end_of_test;
    endtask
    task automatic do_reset(input logic mode);
        rst_n = 1'h0;
        password_mode = mode;
        repeat (10) @(posedge clk);
        #1;
        rst_n = 1'h1;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [24:0] a, input logic e);
        host.issue(2, a, 1'h0);
        chk({rd_v, rd_d}, {1'h1, e});
    endtask
    task automatic awr(input logic [24:0] a, input logic [1:0] e);
        host.issue(6, a, 1'h0);
        chk({wr_g, wr_r}, e);
        chk({1'h0, perr}, {1'h0, e[0]});
        host.issue(8, a, 1'h0);
    endtask
    // Factory state after power-up, top-sector bits included.
    task automatic t_power_up;
        do_reset(1'h0);
        chk({1'h0, lock}, 2'h1);
        rd(25'h0000000, 1'h1);
        rd(25'h1FFF000, 1'h1);
        awr(25'h0030000, 2'h2);
    endtask
    // Program one block bit and one top sector bit.
    task automatic t_program;
        host.issue(0, 25'h0050000, 1'h0);
        chk({1'h0, busy}, 2'h1);
        host.issue(7, 25'h0000000, 1'h0);
        chk({1'h0, rd_g}, 2'h0);
        wait_idle;
        rd(25'h0050000, 1'h0);
        rd(25'h0060000, 1'h1);
        awr(25'h0050000, 2'h1);
        host.issue(0, 25'h1FFF000, 1'h0);
        wait_idle;
        rd(25'h1FFE000, 1'h1);
        rd(25'h1FFF000, 1'h0);
    endtask
    // Dynamic bits protect and release a block on demand.
    task automatic t_dynamic;
        host.issue(3, 25'h0030000, 1'h0);
        awr(25'h0030000, 2'h1);
        host.issue(3, 25'h0030000, 1'h1);
        awr(25'h0030000, 2'h2);
        ce = 1'h0;
        host.issue(3, 25'h0030000, 1'h0);
        ce = 1'h1;
        awr(25'h0030000, 2'h2);
    endtask
    // Erase needs no address and clears every programmed bit.
    task automatic t_erase;
        host.issue(1, 25'h0000000, 1'h0);
        wait_idle;
        rd(25'h0050000, 1'h1);
        rd(25'h1FFF000, 1'h1);
        host.issue(7, 25'h0000000, 1'h0);
        chk({1'h0, rd_g}, 2'h1);
    endtask
    // Cleared lock freezes the bits and survives a software reset.
    task automatic t_lock;
        host.issue(4, 25'h0000000, 1'h0);
        chk({1'h0, lock}, 2'h0);
        host.issue(5, 25'h0000000, 1'h0);
        chk({1'h0, lock}, 2'h0);
        host.issue(0, 25'h0050000, 1'h0);
        chk({busy, perr}, 2'h1);
        host.issue(8, 25'h0000000, 1'h0);
        rd(25'h0050000, 1'h1);
        host.issue(3, 25'h0030000, 1'h0);
        awr(25'h0030000, 2'h1);
        @(posedge clk);
        #1;
        soft_reset = 1'h1;
        @(posedge clk);
        #1;
        soft_reset = 1'h0;
        chk({1'h0, lock}, 2'h0);
        awr(25'h0030000, 2'h2);
    endtask
    // Password mode starts locked until a matched password.
    task automatic t_password;
        do_reset(1'h1);
        chk({1'h0, lock}, 2'h0);
        host.issue(5, 25'h0000000, 1'h0);
        chk({1'h0, lock}, 2'h1);
        host.issue(0, 25'h0070000, 1'h0);
        chk({1'h0, busy}, 2'h1);
        wait_idle;
        rd(25'h0070000, 1'h0);
    endtask
    // Bottom orientation after a reset: programmed bits survive it.
    task automatic t_bottom;
        do_reset(1'h0);
        chk({1'h0, lock}, 2'h1);
        top_sel = 1'h1;
        rd(25'h0007000, 1'h0);
        rd(25'h0070000, 1'h1);
        rd(25'h1FFF000, 1'h1);
    endtask
    initial
    begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        errors = 0;
        checked = 0;
        rst_n = 1'h0;
        soft_reset = 1'h0;
        password_mode = 1'h0;
        ce = 1'h1;
        top_sel = 1'h0;
        t_power_up;
        t_program;
        t_dynamic;
        t_erase;
        t_lock;
        t_password;
        t_bottom;
        end_of_test;
    end
endmodule
